// >>> inc/lube_pkg.sv
// Constants, register map and display screens of the no-flow monitor.
// Assumes a 100 MHz system clock.
package lube_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_MS = 500;
    localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam int TIMEOUT_MIN_S = 30;
    localparam int TIMEOUT_MAX_S = 240;
    localparam int TIMEOUT_DEF_S = 120;
    localparam int TIMEOUT_STEP_S = 10;
    localparam int FAULT_HOLD_S = 30;
    localparam int POL_RETURN_S = 30;
    localparam int UPLOAD_WAIT_S = 5;
    localparam int INTERVAL_MIN = 30;
    localparam int INTERVAL_S = INTERVAL_MIN * 60;
    localparam int HOUR_S = 3600;
    localparam int HIST_N = 6;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LAST = 8'h08;
    localparam logic [7:0] ADDR_MEAN = 8'h0C;
    localparam logic [7:0] ADDR_RUNNING = 8'h10;
    localparam logic [7:0] ADDR_HOURS = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    localparam logic [7:0] ADDR_CHARGE = 8'h1C;
    localparam logic [7:0] ADDR_TREND_SEL = 8'h20;
    localparam logic [7:0] ADDR_TREND_DATA = 8'h24;
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_TO_LSB = 8;
    localparam int CFG_CLR_BIT = 31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic RESET_POL_NC = 1'h0;
    typedef enum logic [3:0] {
        SCR_DEFAULT = 4'h0,
        SCR_RUNNING = 4'h1,
        SCR_HOURS = 4'h3,
        SCR_COUNT = 4'h2,
        SCR_CHARGE = 4'h6,
        SCR_UPLOAD = 4'h7,
        SCR_CONFIG = 4'h5,
        SCR_TIMEOUT = 4'h4,
        SCR_GAP = 4'hC,
        SCR_POLARITY = 4'hD,
        SCR_UPLOAD_IN_PROGRESS = 4'hF,
        SCR_FAULT = 4'hE,
        SCR_ALARM = 4'hA
    } screen_e;
endpackage : lube_pkg

// >>> rtl/lube_no_flow_monitor.sv
// No-flow watchdog for a lubricant divider block, with AXI4-Lite registers.
// Pins are asynchronous and pass two flip-flops; buttons are debounced outside.
//
// Overview of operation
// - Switch input rising edges are counted as divider block cycles.
// - One pulse on the pulse output per detected cycle.
// - Each output pulse lasts 500 ms regardless of cycle length.
// - A detected cycle puts the alarm contact into its running state.
// - Timeout with no cycle returns the contact to its static opposite state.
// - Contact polarity is stored: open or closed while cycling.
// - Set press clears alarm, shows last/mean screen, contact to running.
// - Duration of the last complete cycle is kept in seconds.
// - Mean of the six most recent cycle durations, in seconds.
// - Mode presses step running, hours, count, charge screens in order.
// - Running period shows live seconds of the cycle in progress.
// - Operating hours accumulate since the last memory reset.
// - Cycle count accumulates since the last memory reset.
// - Low supply voltage forces the alarm state.
// - Alarm entry shows alarm screen; cycles return display to default.
// - Set then five modes shows upload prompt; set starts upload.
// - Unanswered upload shows fault, then default screen after 30 s.
// - Set then six modes shows config prompt; set enters timeout item.
// - Set in timeout item steps timeout within 30 to 240 s.
// - Timeout resets to 120 s.
// - Two more modes reach polarity item; set toggles polarity.
// - After polarity is set, return to default screen 30 s later.
// - Cell charge is resampled every 30 minute interval.
// - Trend records go to a ring store overwriting the oldest.
// - Trend and configuration are kept for a nonvolatile store; the code copies out only count and hours on nv_strobe.
// - Every 30 minutes cycle data is copied out for nonvolatile storage.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module lube_no_flow_monitor
    import lube_pkg::*;
#(
    parameter int SEC_CYCLES = CLK_HZ,
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TREND_DEPTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic switch_in,
    input wire logic set_btn,
    input wire logic mode_btn,
    input wire logic supply_low,
    input wire logic upload_ack,
    input wire logic [7:0] cell_level,
    output logic pulse_out,
    output logic alarm_contact,
    output logic [3:0] screen_code,
    output logic upload_req,
    output logic nv_strobe,
    output logic [31:0] nv_count,
    output logic [23:0] nv_hours,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int SW = $clog2(SEC_CYCLES + 1);
    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam int TW = $clog2(TREND_DEPTH);

    if (SEC_CYCLES < 2 || PULSE_CYCLES < 1 || TREND_DEPTH < 2 ||
        (TREND_DEPTH & (TREND_DEPTH - 1)) != 0) begin : bad_params
        $error("lube_no_flow_monitor: unusable parameter values");
    end

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] prev;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [SW-1:0] div;
        logic tick;
        logic [PW-1:0] pulse_cnt;
        logic pend;
        logic pulse_out;
        logic alarm;
        logic contact;
        logic pol;
        logic [7:0] timeout_s;
        logic [7:0] idle_s;
        logic [15:0] now_s;
        logic [15:0] last_s;
        logic [HIST_N-1:0][15:0] hist;
        logic [15:0] mean_s;
        logic [11:0] hour_sec;
        logic [23:0] hours;
        logic [31:0] count;
        logic [10:0] ivl_s;
        logic [15:0] ivl_cycles;
        logic [7:0] charge;
        logic [TREND_DEPTH-1:0][15:0] trend;
        logic [TW-1:0] wp;
        logic [TW-1:0] trend_sel;
        logic nv_strobe;
        logic [31:0] nv_count;
        logic [23:0] nv_hours;
        screen_e screen;
        logic [7:0] menu_s;
        logic armed;
        logic upload_req;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s r;
    state_s n;

    function automatic logic is_readout(input screen_e s);
        return s == SCR_DEFAULT || s == SCR_RUNNING || s == SCR_HOURS ||
            s == SCR_COUNT || s == SCR_CHARGE || s == SCR_ALARM;
    endfunction : is_readout

    function automatic logic [7:0] clamp_to(input logic [7:0] v);
        if (v < 8'(TIMEOUT_MIN_S)) return 8'(TIMEOUT_MIN_S);
        if (v > 8'(TIMEOUT_MAX_S)) return 8'(TIMEOUT_MAX_S);
        return v;
    endfunction : clamp_to

    logic [4:0] rise;
    logic cyc_ev;
    logic set_ev;
    logic mode_ev;
    logic low_s;
    logic ack_s;
    logic set_clr;
    logic expire;
    logic mem_clr;
    assign rise = r.s2 & ~r.prev;
    assign cyc_ev = rise[0];
    assign set_ev = rise[1];
    assign mode_ev = rise[2];
    assign low_s = r.s2[3];
    assign ack_s = r.s2[4];
    assign set_clr = set_ev && is_readout(r.screen);
    // Idle seconds saturate, so a held alarm never wraps back to running
    assign expire = !cyc_ev && !set_clr && r.idle_s >= r.timeout_s;
    assign mem_clr = r.aw_got && r.w_got && !r.bvalid && r.awaddr == ADDR_CONFIG &&
        r.wstrb[3] && r.wdata[CFG_CLR_BIT];

    always_comb begin
        logic [18:0] sum;
        sum = '0;
        n = r;
        n.s1 = {upload_ack, supply_low, mode_btn, set_btn, switch_in};
        n.s2 = r.s1;
        n.prev = r.s2;
        n.c1 = cell_level;
        n.c2 = r.c1;
        n.tick = 1'b0;
        n.nv_strobe = 1'b0;
        if (r.div == SW'(SEC_CYCLES - 1)) begin
            n.div = '0;
            n.tick = 1'b1;
        end else begin
            n.div = r.div + 1'b1;
        end
        // A cycle during a pulse is queued, not merged into it
        if (r.pulse_cnt != '0) begin
            n.pulse_cnt = r.pulse_cnt - 1'b1;
            if (r.pulse_cnt == PW'(1)) n.pulse_out = 1'b0;
            if (cyc_ev) n.pend = 1'b1;
        end else if (cyc_ev || r.pend) begin
            n.pulse_cnt = PW'(PULSE_CYCLES);
            n.pulse_out = 1'b1;
            n.pend = cyc_ev && r.pend;
        end
        if (cyc_ev) begin
            n.idle_s = '0;
            n.last_s = r.now_s;
            n.hist = {r.hist[HIST_N-2:0], r.now_s};
            for (int i = 0; i < HIST_N; i++) sum = sum + 19'(n.hist[i]);
            n.mean_s = 16'(sum / 19'(HIST_N));
            n.now_s = '0;
            n.count = r.count + 1'b1;
            n.ivl_cycles = r.ivl_cycles + 1'b1;
        end else if (r.tick) begin
            if (r.now_s != 16'hFFFF) n.now_s = r.now_s + 1'b1;
            if (r.idle_s != 8'hFF) n.idle_s = r.idle_s + 1'b1;
        end
        if (set_clr) n.idle_s = '0;
        if (r.tick && !r.alarm) begin
            if (r.hour_sec == 12'(HOUR_S - 1)) begin
                n.hour_sec = '0;
                n.hours = r.hours + 1'b1;
            end else begin
                n.hour_sec = r.hour_sec + 1'b1;
            end
        end
        if (r.tick) begin
            if (r.ivl_s == 11'(INTERVAL_S - 1)) begin
                n.ivl_s = '0;
                n.charge = r.c2;
                n.trend[r.wp] = r.ivl_cycles;
                n.wp = r.wp + 1'b1;
                n.nv_count = r.count;
                n.nv_hours = r.hours;
                n.nv_strobe = 1'b1;
                n.ivl_cycles = {15'h0, cyc_ev};
            end else begin
                n.ivl_s = r.ivl_s + 1'b1;
            end
        end
        if (mem_clr) begin
            n.hours = '0;
            n.hour_sec = '0;
            n.count = '0;
            n.trend = '0;
            n.wp = '0;
        end
        // Set wins over clear, so an expiry is never dropped
        if (expire || low_s) n.alarm = 1'b1;
        else if (cyc_ev || set_clr) n.alarm = 1'b0;

        case (r.screen)
            SCR_DEFAULT, SCR_ALARM: if (mode_ev) n.screen = SCR_RUNNING;
            SCR_RUNNING: if (mode_ev) n.screen = SCR_HOURS;
            SCR_HOURS: if (mode_ev) n.screen = SCR_COUNT;
            SCR_COUNT: if (mode_ev) n.screen = SCR_CHARGE;
            SCR_CHARGE: if (mode_ev) n.screen = SCR_UPLOAD;
            SCR_UPLOAD: begin
                if (set_ev) begin
                    n.screen = SCR_UPLOAD_IN_PROGRESS;
                    n.upload_req = 1'b1;
                    n.menu_s = '0;
                end else if (mode_ev) begin
                    n.screen = SCR_CONFIG;
                end
            end
            SCR_CONFIG: begin
                if (set_ev) n.screen = SCR_TIMEOUT;
                else if (mode_ev) n.screen = SCR_DEFAULT;
            end
            SCR_TIMEOUT: begin
                if (set_ev) begin
                    if (r.timeout_s >= 8'(TIMEOUT_MAX_S)) n.timeout_s = 8'(TIMEOUT_MIN_S);
                    else n.timeout_s = clamp_to(r.timeout_s + 8'(TIMEOUT_STEP_S));
                end else if (mode_ev) begin
                    n.screen = SCR_GAP;
                end
            end
            SCR_GAP: if (mode_ev) n.screen = SCR_POLARITY;
            SCR_POLARITY: begin
                if (set_ev) begin
                    n.pol = !r.pol;
                    n.armed = 1'b1;
                    n.menu_s = '0;
                end else if (mode_ev) begin
                    n.screen = SCR_DEFAULT;
                    n.armed = 1'b0;
                end else if (r.tick && r.armed) begin
                    if (r.menu_s == 8'(POL_RETURN_S - 1)) begin
                        n.screen = SCR_DEFAULT;
                        n.armed = 1'b0;
                    end else begin
                        n.menu_s = r.menu_s + 1'b1;
                    end
                end
            end
            SCR_UPLOAD_IN_PROGRESS: begin
                if (ack_s) begin
                    n.screen = SCR_DEFAULT;
                    n.upload_req = 1'b0;
                end else if (r.tick) begin
                    if (r.menu_s == 8'(UPLOAD_WAIT_S - 1)) begin
                        n.screen = SCR_FAULT;
                        n.upload_req = 1'b0;
                        n.menu_s = '0;
                    end else begin
                        n.menu_s = r.menu_s + 1'b1;
                    end
                end
            end
            SCR_FAULT: begin
                if (r.tick) begin
                    if (r.menu_s == 8'(FAULT_HOLD_S - 1)) n.screen = SCR_DEFAULT;
                    else n.menu_s = r.menu_s + 1'b1;
                end
            end
            default: n.screen = SCR_DEFAULT;
        endcase
        if (set_clr) n.screen = SCR_DEFAULT;
        if (n.alarm && !r.alarm && is_readout(n.screen)) n.screen = SCR_ALARM;
        else if (cyc_ev && r.screen == SCR_ALARM) n.screen = SCR_DEFAULT;

        if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
        if (r.awready && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (r.awaddr)
                ADDR_CONFIG: begin
                    if (r.wstrb[0]) n.pol = r.wdata[CFG_POL_BIT];
                    if (r.wstrb[1]) n.timeout_s = clamp_to(r.wdata[CFG_TO_LSB+:8]);
                end
                ADDR_TREND_SEL: if (r.wstrb[0]) n.trend_sel = r.wdata[TW-1:0];
                ADDR_STATUS, ADDR_LAST, ADDR_MEAN, ADDR_RUNNING, ADDR_HOURS,
                ADDR_COUNT, ADDR_CHARGE, ADDR_TREND_DATA: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        if (r.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CONFIG: n.rdata = {16'h0, r.timeout_s, 7'h0, r.pol};
                ADDR_STATUS: n.rdata = {24'h0, r.screen, r.upload_req, low_s,
                    r.contact, r.alarm};
                ADDR_LAST: n.rdata = {16'h0, r.last_s};
                ADDR_MEAN: n.rdata = {16'h0, r.mean_s};
                ADDR_RUNNING: n.rdata = {16'h0, r.now_s};
                ADDR_HOURS: n.rdata = {8'h0, r.hours};
                ADDR_COUNT: n.rdata = r.count;
                ADDR_CHARGE: n.rdata = {24'h0, r.charge};
                ADDR_TREND_SEL: n.rdata = 32'(r.trend_sel);
                ADDR_TREND_DATA: n.rdata = {16'h0, r.trend[r.trend_sel]};
                default: begin
                    n.rdata = '0;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
        n.contact = n.alarm ? !n.pol : n.pol;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.alarm <= 1'b1;
            r.pol <= RESET_POL_NC;
            r.contact <= !RESET_POL_NC;
            r.timeout_s <= 8'(TIMEOUT_DEF_S);
            r.screen <= SCR_ALARM;
        end else begin
            r <= n;
        end
    end

    assign pulse_out = r.pulse_out;
    assign alarm_contact = r.contact;
    assign screen_code = r.screen;
    assign upload_req = r.upload_req;
    assign nv_strobe = r.nv_strobe;
    assign nv_count = r.nv_count;
    assign nv_hours = r.nv_hours;
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    logic [31:0] hi_len;
    always_ff @(posedge aclk) begin
        if (!aresetn) hi_len <= '0;
        else if (pulse_out) hi_len <= hi_len + 1'b1;
        else hi_len <= '0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence good_cycle;
        cyc_ev && !low_s;
    endsequence
    sequence upload_start;
        r.screen == SCR_UPLOAD && set_ev;
    endsequence

    pulse_width_a: assert property ($fell(pulse_out) |-> hi_len == 32'(PULSE_CYCLES))
        else $error("pulse width wrong");
    pulse_start_a: assert property (cyc_ev && r.pulse_cnt == '0 && !r.pend |=> pulse_out)
        else $error("cycle did not start a pulse");
    run_contact_a: assert property (good_cycle |=> alarm_contact == r.pol)
        else $error("contact not running after cycle");
    expire_contact_a: assert property (expire |=> r.alarm && alarm_contact == !r.pol)
        else $error("contact not static after timeout");
    low_alarm_a: assert property (low_s |=> r.alarm ##1 (r.alarm || !$past(low_s)))
        else $error("low supply did not alarm");
    set_clear_a: assert property (set_clr && !low_s |=> !r.alarm && r.screen == SCR_DEFAULT)
        else $error("set press did not clear alarm");
    last_period_a: assert property (cyc_ev |=> r.last_s == $past(r.now_s))
        else $error("last period not captured");
    mode_step_a: assert property (mode_ev && r.screen == SCR_RUNNING && !expire && !low_s &&
        !set_ev |=> r.screen == SCR_HOURS)
        else $error("mode step order wrong");
    timeout_range_a: assert property (r.timeout_s >= 8'(TIMEOUT_MIN_S) &&
        r.timeout_s <= 8'(TIMEOUT_MAX_S))
        else $error("timeout out of range");
    upload_go_a: assert property (upload_start |=> r.screen == SCR_UPLOAD_IN_PROGRESS && upload_req)
        else $error("upload not started");
endmodule : lube_no_flow_monitor

// >>> testbench/plc_model.sv
// Control panel side: counts output pulses, measures their width,
// and answers an upload after ACK_DELAY cycles when enabled.
// Assumes it shares aclk with the monitor.
`timescale 1ns/1ps
module plc_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic aclk,
    input wire logic pulse_out,
    input wire logic upload_req,
    input wire logic ack_en,
    output logic upload_ack,
    output int pulse_cnt,
    output int width
);
    int run = 0;
    int wait_cnt = 0;

    initial begin
        upload_ack = 1'b0;
        pulse_cnt = 0;
        width = 0;
    end

    // A pulse is counted when it ends, so queued pulses need a low gap
    always @(posedge aclk) begin
        if (pulse_out) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            pulse_cnt <= pulse_cnt + 1;
            run <= 0;
        end
        wait_cnt <= (upload_req && ack_en) ? wait_cnt + 1 : 0;
        upload_ack <= (wait_cnt >= ACK_DELAY);
    end
endmodule : plc_model

// >>> testbench/tb_lube_no_flow_monitor.sv
// Bench for the no-flow monitor: pulses, contact, menus, registers.
// Assumes one 100 MHz clock; seconds and pulses are shortened.
`timescale 1ns/1ps
module tb_lube_no_flow_monitor;
    import lube_pkg::*;
    localparam int SEC = 20;
    localparam int PW = 5;
    typedef struct {logic [31:0] lo; logic [31:0] hi; logic [1:0] resp;} note_s;
    logic aclk = 0;
    logic aresetn = 0;
    logic switch_in = 0;
    logic set_btn = 0;
    logic mode_btn = 0;
    logic supply_low = 0;
    logic ack_en = 0;
    logic upload_ack;
    logic [7:0] cell_level = 0;
    logic pulse_out, alarm_contact, upload_req, nv_strobe;
    logic [3:0] screen_code;
    logic [31:0] nv_count;
    logic [23:0] nv_hours;
    logic [7:0] s_axi_awaddr = 0;
    logic [7:0] s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32'h14d139e8;
    int ncyc = 0;
    int pulses, pwidth, n;
    note_s exp_q[$];
    note_s nt;
    screen_e walk[5] = '{SCR_RUNNING, SCR_HOURS, SCR_COUNT, SCR_CHARGE, SCR_UPLOAD};

    always #5 aclk = ~aclk;

    lube_no_flow_monitor #(.SEC_CYCLES(SEC), .PULSE_CYCLES(PW)) uut (.aclk, .aresetn,
        .switch_in, .set_btn, .mode_btn, .supply_low, .upload_ack, .cell_level, .pulse_out,
        .alarm_contact, .screen_code, .upload_req, .nv_strobe, .nv_count, .nv_hours,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    plc_model model (.aclk, .pulse_out, .upload_req, .ack_en, .upload_ack,
        .pulse_cnt(pulses), .width(pwidth));

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic hang(input string nm);
        error_cnt++;
        $display("[ERR] %s expected handshake seen timeout", nm);
        test_done();
    endtask : hang

    // Read data are judged here, against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            nt = exp_q.pop_front();
            n_checks++;
            if ((s_axi_rdata >= nt.lo && s_axi_rdata <= nt.hi
                    && s_axi_rresp === nt.resp) !== 1'b1) begin
                error_cnt++;
                $display("[ERR] rdata expected %h..%h seen %h", nt.lo, nt.hi, s_axi_rdata);
            end
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 200);
        s_axi_bready <= 1'b0;
        if (k >= 200) hang("bvalid");
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
        tick(1);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
            input logic [1:0] r);
        int k;
        k = 0;
        exp_q.push_back('{lo, hi, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 200);
        s_axi_rready <= 1'b0;
        if (k >= 200) hang("rvalid");
        tick(1);
    endtask : axi_rd

    task automatic cyc(input int h, input int l);
        switch_in <= 1'b1;
        tick(h);
        switch_in <= 1'b0;
        tick(l);
        ncyc++;
    endtask : cyc

    task automatic press(input bit s);
        if (s)
            set_btn <= 1'b1;
        else
            mode_btn <= 1'b1;
        tick(2);
        set_btn <= 1'b0;
        mode_btn <= 1'b0;
        tick(5);
    endtask : press

    initial begin
        tick(12);
        aresetn <= 1'b1;
        cell_level <= 8'($random(seed));
        tick(1);
        chk("screen", SCR_ALARM, {28'h0, screen_code});
        axi_rd(ADDR_CONFIG, 32'h7800, 32'h7800, RESP_OKAY);
        $display("test reset done");
        cyc(3, 3);
        tick(PW + 4);
        chk("contact", 1'b0, alarm_contact);
        chk("screen", SCR_DEFAULT, {28'h0, screen_code});
        cyc(2, 2);
        cyc(2, 3 * PW);
        chk("pulses", 3, pulses);
        chk("width", PW, pwidth);
        axi_rd(ADDR_COUNT, ncyc, ncyc, RESP_OKAY);
        repeat (7) begin
            cyc(3, 3);
            tick(3 * SEC - 6);
        end
        axi_rd(ADDR_LAST, 2, 4, RESP_OKAY);
        axi_rd(ADDR_MEAN, 2, 4, RESP_OKAY);
        axi_rd(ADDR_RUNNING, 2, 4, RESP_OKAY);
        $display("test pulses done");
        press(1);
        foreach (walk[i]) begin
            press(0);
            chk("screen", walk[i], {28'h0, screen_code});
        end
        press(1);
        chk("screen", SCR_UPLOAD_IN_PROGRESS, {28'h0, screen_code});
        chk("upload", 1'b1, upload_req);
        tick(7 * SEC);
        chk("screen", SCR_FAULT, {28'h0, screen_code});
        tick(26 * SEC);
        chk("screen", SCR_FAULT, {28'h0, screen_code});
        tick(5 * SEC);
        chk("screen", SCR_DEFAULT, {28'h0, screen_code});
        ack_en <= 1'b1;
        press(1);
        repeat (5) press(0);
        press(1);
        tick(10);
        chk("screen", SCR_DEFAULT, {28'h0, screen_code});
        chk("upload", 1'b0, upload_req);
        ack_en <= 1'b0;
        $display("test upload done");
        press(1);
        repeat (6) press(0);
        chk("screen", SCR_CONFIG, {28'h0, screen_code});
        press(1);
        chk("screen", SCR_TIMEOUT, {28'h0, screen_code});
        press(1);
        axi_rd(ADDR_CONFIG, 32'h8200, 32'h8200, RESP_OKAY);
        press(0);
        press(0);
        chk("screen", SCR_POLARITY, {28'h0, screen_code});
        press(1);
        axi_rd(ADDR_CONFIG, 32'h8201, 32'h8201, RESP_OKAY);
        chk("contact", 1'b1, alarm_contact);
        tick(27 * SEC);
        chk("screen", SCR_POLARITY, {28'h0, screen_code});
        tick(5 * SEC);
        chk("screen", SCR_DEFAULT, {28'h0, screen_code});
        $display("test config done");
        axi_wr(ADDR_CONFIG, 32'h1E01, RESP_OKAY);
        cyc(3, 3);
        tick(30 * SEC - 40);
        chk("contact", 1'b1, alarm_contact);
        cyc(3, 3);
        tick(30 * SEC - 40);
        chk("contact", 1'b1, alarm_contact);
        tick(60);
        chk("contact", 1'b0, alarm_contact);
        chk("screen", SCR_ALARM, {28'h0, screen_code});
        press(1);
        chk("contact", 1'b1, alarm_contact);
        chk("screen", SCR_DEFAULT, {28'h0, screen_code});
        supply_low <= 1'b1;
        tick(6);
        chk("contact", 1'b0, alarm_contact);
        supply_low <= 1'b0;
        press(1);
        $display("test alarm done");
        axi_wr(ADDR_CONFIG, 32'hFA01, RESP_OKAY);
        axi_rd(ADDR_CONFIG, 32'hF001, 32'hF001, RESP_OKAY);
        axi_wr(ADDR_CONFIG, 32'h0A01, RESP_OKAY);
        axi_rd(ADDR_CONFIG, 32'h1E01, 32'h1E01, RESP_OKAY);
        axi_wr(8'h40, 32'h0, RESP_SLVERR);
        axi_rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
        axi_wr(ADDR_COUNT, 32'h0, RESP_OKAY);
        axi_rd(ADDR_COUNT, ncyc, ncyc, RESP_OKAY);
        $display("test registers done");
        n = 0;
        while (!nv_strobe && n < 40000) begin
            tick(1);
            n++;
        end
        if (n >= 40000) hang("nv_strobe");
        chk("nv_count", ncyc, nv_count);
        chk("nv_hours", 32'h0, {8'h0, nv_hours});
        axi_rd(ADDR_CHARGE, cell_level, cell_level, RESP_OKAY);
        axi_rd(ADDR_TREND_DATA, ncyc, ncyc, RESP_OKAY);
        axi_wr(ADDR_CONFIG, 32'h80001E01, RESP_OKAY);
        axi_rd(ADDR_COUNT, 32'h0, 32'h0, RESP_OKAY);
        $display("test interval done");
        tick(4);
        test_done();
    end
endmodule : tb_lube_no_flow_monitor
